//--- rta_regs.vh
// register offsets, field positions, reset values and constants of the alarm block
`ifndef RTA_REGS_VH
`define RTA_REGS_VH

`define RTA_ADDR_SEC      4'h1
`define RTA_ADDR_MIN      4'h2
`define RTA_ADDR_HOUR     4'h3
`define RTA_ADDR_DATE     4'h5
`define RTA_ADDR_MONTH    4'h6
`define RTA_ADDR_YEAR     4'h7
`define RTA_ADDR_FCOMP    4'h8
`define RTA_ADDR_WDOG     4'h9
`define RTA_ADDR_AL_MON   4'hA
`define RTA_ADDR_AL_DAY   4'hB
`define RTA_ADDR_AL_HOUR  4'hC
`define RTA_ADDR_AL_MIN   4'hD
`define RTA_ADDR_AL_SEC   4'hE
`define RTA_ADDR_FLAGS    4'hF

`define RTA_BIT_MASK_HI   7
`define RTA_BIT_MASK5     6
`define RTA_BIT_CENT_HI   7
`define RTA_BIT_CENT_LO   6
`define RTA_BIT_OSC_HALT  7
`define RTA_BIT_OUT_LVL   7
`define RTA_BIT_AL_IE     7
`define RTA_BIT_OF_IE     6
`define RTA_BIT_WDF       7
`define RTA_BIT_AF        6
`define RTA_BIT_OF        2

`define RTA_MASK_SEC      8'h7F
`define RTA_MASK_MIN      8'h7F
`define RTA_MASK_HOUR     8'h3F
`define RTA_MASK_DATE     8'h3F
`define RTA_MASK_MONTH    8'h1F
`define RTA_MASK_AL_MON   8'h1F

`define RTA_RST_ZERO      8'h00
`define RTA_RST_ONE       8'h01
`define RTA_RST_FCOMP     8'h80

`define RTA_MAX_SEC       8'h59
`define RTA_MAX_MIN       8'h59
`define RTA_MAX_HOUR      8'h23
`define RTA_MAX_MONTH     8'h12
`define RTA_MAX_YEAR      8'h99
`define RTA_FEBRUARY      8'h02
`define RTA_WDOG_SRC_MAX  3'h4

`define RTA_RPT_SECOND    5'h1F
`define RTA_RPT_MINUTE    5'h1E
`define RTA_RPT_HOUR      5'h1C
`define RTA_RPT_DAY       5'h18
`define RTA_RPT_MONTH     5'h10
`define RTA_RPT_YEAR      5'h00

`endif

//--- rta_alarm_logic.v
// alarm, calendar, century, oscillator-fail and interrupt pin logic of the clock
//
// Summary of operation
// RQ1: alarm settings held at 0Ah through 0Eh
// RQ2: repeat mask bits sit in alarm register tops
// RQ3: mask code selects second to year repeat
// RQ4: undefined mask codes act as every second
// RQ5: match sets alarm flag; pin needs enable
// RQ6: software disables alarm by zeroing day, mask
// RQ7: match deferred while pointer rests on flags
// RQ8: write to second alarm moves pointer to flags
// RQ9: flag read returns, clears flag, releases pin
// RQ10: century bits at month register bits 7, 6
// RQ11: century bits count modulo four
// RQ12: century steps when year wraps 99 to 00
// RQ13: february 29 in every year divisible by four
// RQ14: oscillator fail sticks until written zero
// RQ15: fail set at power-up, low supply, halt bit
// RQ16: stoppage while unpowered still leaves flag set
// RQ17: software waits four seconds before clearing fail
// RQ18: software toggles halt bit to restart oscillator
// RQ19: fail with enable drives pin; read keeps it
// RQ20: no source enabled: pin follows output level bit
// RQ21: pin is open drain, never driven high
// RQ22: zero watchdog register disables watchdog source
// RQ23: flag read also clears watchdog timeout flag
`timescale 1ns/100ps
`include "rta_regs.vh"

module rta_alarm_logic
(
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       osc_tick_pin,
  input  wire       osc_run_pin,
  input  wire       ptr_set,
  input  wire [3:0] ptr_value,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output wire [3:0] reg_ptr,
  input  wire       wdog_timeout,
  output wire       wdog_programmed,
  input  wire       int_n_i,
  output wire       int_n_o,
  output wire       int_n_oe
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [7:0] bcd_inc;
  input [7:0] v;
  begin
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  end
endfunction

// tens digit odd needs ones 2 or 6, even needs 0, 4 or 8
function leap_year;
  input [7:0] y;
  begin
    if (y[4])
      leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                  (y[3:0] == 4'h8);
  end
endfunction

function [7:0] month_last;
  input [7:0] m;
  input       is_leap;
  begin
    case (m)
      8'h02:   month_last = is_leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11:
               month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  end
endfunction

// field compare enables {month, date, hour, minute, second}
function [4:0] repeat_fields;
  input [4:0] m;
  begin
    case (m)
      `RTA_RPT_SECOND: repeat_fields = 5'h00;
      `RTA_RPT_MINUTE: repeat_fields = 5'h01;
      `RTA_RPT_HOUR:   repeat_fields = 5'h03;
      `RTA_RPT_DAY:    repeat_fields = 5'h07;
      `RTA_RPT_MONTH:  repeat_fields = 5'h0F;
      `RTA_RPT_YEAR:   repeat_fields = 5'h1F;
      // undefined codes fire every second so a bad setup shows at once
      default:         repeat_fields = 5'h00; // see RQ4
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg [2:0] tick_sync;
reg [2:0] run_sync;
reg       tick_stable;
reg       run_stable;
wire      tick_rise;

assign tick_rise = (tick_sync[1] == tick_sync[2]) && tick_sync[2] &&
                   !tick_stable;

always @(posedge sys_clk)
begin
  if (sys_rst)
  begin
    tick_sync   <= 3'h0;
    run_sync    <= 3'h0;
    tick_stable <= 1'b0;
    run_stable  <= 1'b0;
  end
  else
  begin
    tick_sync <= {tick_sync[1:0], osc_tick_pin};
    run_sync  <= {run_sync[1:0], osc_run_pin};
    if (tick_sync[1] == tick_sync[2])
      tick_stable <= tick_sync[2];
    if (run_sync[1] == run_sync[2])
      run_stable <= run_sync[2];
  end
end

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] sec;
reg [7:0] min;
reg [7:0] hour;
reg [7:0] date;
reg [7:0] month;
reg [7:0] year;
reg [7:0] fcomp;
reg [7:0] wdog;
reg [7:0] alarm_month_ctrl;
reg [7:0] alarm_day_repeat;
reg [7:0] alarm_hour_repeat;
reg [7:0] alarm_minute_repeat;
reg [7:0] alarm_second_repeat;
reg [3:0] ptr;
reg       alarm_match_flag;
reg       alarm_pending;
reg       osc_fail_flag;
reg       wdog_timeout_flag;
reg       tick_done;

wire       osc_halt_bit;
wire       alarm_irq_enable;
wire       osc_fail_irq_enable;
wire [4:0] repeat_mask;
wire [4:0] fld_en;
wire       leap;
wire       wr_flags;
wire       rd_flags;
wire       alarm_hit;
wire [7:0] flags_val;
wire [7:0] month_inc;

assign osc_halt_bit        = sec[`RTA_BIT_OSC_HALT];
assign alarm_irq_enable    = alarm_month_ctrl[`RTA_BIT_AL_IE];
assign osc_fail_irq_enable = alarm_month_ctrl[`RTA_BIT_OF_IE];
assign repeat_mask = {alarm_day_repeat[`RTA_BIT_MASK5],
                      alarm_day_repeat[`RTA_BIT_MASK_HI],
                      alarm_hour_repeat[`RTA_BIT_MASK_HI],
                      alarm_minute_repeat[`RTA_BIT_MASK_HI],
                      alarm_second_repeat[`RTA_BIT_MASK_HI]}; // see RQ2
assign fld_en = repeat_fields(repeat_mask); // see RQ3
assign leap   = leap_year(year); // see RQ13
assign month_inc = bcd_inc(month & `RTA_MASK_MONTH);
assign reg_ptr  = ptr;
assign wr_flags = reg_wr && !ptr_set && ptr == `RTA_ADDR_FLAGS;
assign rd_flags = reg_rd && !reg_wr && !ptr_set &&
                  ptr == `RTA_ADDR_FLAGS;

// compare on the cycle after the calendar step, against fresh time
assign alarm_hit = tick_done &&
  (!fld_en[0] || (sec & `RTA_MASK_SEC) ==
                 (alarm_second_repeat & `RTA_MASK_SEC)) &&
  (!fld_en[1] || min == (alarm_minute_repeat & `RTA_MASK_MIN)) &&
  (!fld_en[2] || hour == (alarm_hour_repeat & `RTA_MASK_HOUR)) &&
  (!fld_en[3] || date == (alarm_day_repeat & `RTA_MASK_DATE)) &&
  (!fld_en[4] || (month & `RTA_MASK_MONTH) ==
                 (alarm_month_ctrl & `RTA_MASK_AL_MON)); // see RQ1

// a zero register or a reserved clock source leaves the watchdog off
assign wdog_programmed = (wdog != `RTA_RST_ZERO) &&
  ({wdog[7], wdog[1:0]} <= `RTA_WDOG_SRC_MAX); // see RQ22

assign flags_val = ({7'h00, wdog_timeout_flag} << `RTA_BIT_WDF) |
                   ({7'h00, alarm_match_flag} << `RTA_BIT_AF) |
                   ({7'h00, osc_fail_flag} << `RTA_BIT_OF);

////////////////////////////////////////////////////////////////////////////////
// calendar, registers and flags

always @(posedge sys_clk)
begin
  if (sys_rst)
  begin
    sec                 <= `RTA_RST_ZERO;
    min                 <= `RTA_RST_ZERO;
    hour                <= `RTA_RST_ZERO;
    date                <= `RTA_RST_ONE;
    month               <= `RTA_RST_ONE;
    year                <= `RTA_RST_ZERO;
    fcomp               <= `RTA_RST_FCOMP;
    wdog                <= `RTA_RST_ZERO;
    alarm_month_ctrl    <= `RTA_RST_ZERO;
    alarm_day_repeat    <= `RTA_RST_ZERO;
    alarm_hour_repeat   <= `RTA_RST_ZERO;
    alarm_minute_repeat <= `RTA_RST_ZERO;
    alarm_second_repeat <= `RTA_RST_ZERO;
    ptr                 <= 4'h0;
    reg_rdata           <= `RTA_RST_ZERO;
    alarm_match_flag    <= 1'b0;
    alarm_pending       <= 1'b0;
    osc_fail_flag       <= 1'b1; // see RQ15
    wdog_timeout_flag   <= 1'b0;
    tick_done           <= 1'b0;
  end
  else
  begin
    tick_done <= tick_rise && !osc_halt_bit;
    // calendar step; the halt bit freezes time
    if (tick_rise && !osc_halt_bit)
    begin
      if ((sec & `RTA_MASK_SEC) == `RTA_MAX_SEC)
      begin
        sec <= {osc_halt_bit, 7'h00};
        if (min == `RTA_MAX_MIN)
        begin
          min <= `RTA_RST_ZERO;
          if (hour == `RTA_MAX_HOUR)
          begin
            hour <= `RTA_RST_ZERO;
            if (date == month_last(month & `RTA_MASK_MONTH, leap))
            begin
              date <= `RTA_RST_ONE; // see RQ13
              if ((month & `RTA_MASK_MONTH) == `RTA_MAX_MONTH)
              begin
                month[4:0] <= 5'h01;
                if (year == `RTA_MAX_YEAR)
                begin
                  year <= `RTA_RST_ZERO;
                  // century pair wraps from three to zero
                  {month[`RTA_BIT_CENT_HI], month[`RTA_BIT_CENT_LO]} <=
                    {month[`RTA_BIT_CENT_HI], month[`RTA_BIT_CENT_LO]} +
                    2'h1; // see RQ10 see RQ11 see RQ12
                end
                else
                  year <= bcd_inc(year);
              end
              else
                month[4:0] <= month_inc[4:0];
            end
            else
              date <= bcd_inc(date);
          end
          else
            hour <= bcd_inc(hour);
        end
        else
          min <= bcd_inc(min);
      end
      else
        sec <= bcd_inc(sec);
    end

    // alarm event waits while the pointer sits on the flag register
    if (alarm_hit)
      alarm_pending <= 1'b1; // see RQ5 see RQ7
    if (alarm_pending && ptr != `RTA_ADDR_FLAGS)
    begin
      alarm_pending    <= alarm_hit;
      alarm_match_flag <= 1'b1; // see RQ7
    end
    else if (rd_flags)
      alarm_match_flag <= 1'b0; // see RQ9

    // pointer: explicit load beats auto increment
    if (ptr_set)
      ptr <= ptr_value;
    else if (reg_wr || reg_rd)
      ptr <= ptr + 4'h1; // see RQ8

    if (reg_rd && !reg_wr && !ptr_set)
    begin
      case (ptr)
        `RTA_ADDR_SEC:     reg_rdata <= sec;
        `RTA_ADDR_MIN:     reg_rdata <= min;
        `RTA_ADDR_HOUR:    reg_rdata <= hour;
        `RTA_ADDR_DATE:    reg_rdata <= date;
        `RTA_ADDR_MONTH:   reg_rdata <= month;
        `RTA_ADDR_YEAR:    reg_rdata <= year;
        `RTA_ADDR_FCOMP:   reg_rdata <= fcomp;
        `RTA_ADDR_WDOG:    reg_rdata <= wdog;
        `RTA_ADDR_AL_MON:  reg_rdata <= alarm_month_ctrl;
        `RTA_ADDR_AL_DAY:  reg_rdata <= alarm_day_repeat;
        `RTA_ADDR_AL_HOUR: reg_rdata <= alarm_hour_repeat;
        `RTA_ADDR_AL_MIN:  reg_rdata <= alarm_minute_repeat;
        `RTA_ADDR_AL_SEC:  reg_rdata <= alarm_second_repeat;
        `RTA_ADDR_FLAGS:   reg_rdata <= flags_val; // see RQ9
        default:           reg_rdata <= `RTA_RST_ZERO;
      endcase
    end

    // software writes override the calendar step of the same cycle
    if (reg_wr && !ptr_set)
    begin
      case (ptr)
        `RTA_ADDR_SEC:     sec <= reg_wdata;
        `RTA_ADDR_MIN:     min <= reg_wdata & `RTA_MASK_MIN;
        `RTA_ADDR_HOUR:    hour <= reg_wdata & `RTA_MASK_HOUR;
        `RTA_ADDR_DATE:    date <= reg_wdata & `RTA_MASK_DATE;
        `RTA_ADDR_MONTH:   month <= reg_wdata;
        `RTA_ADDR_YEAR:    year <= reg_wdata;
        `RTA_ADDR_FCOMP:   fcomp <= reg_wdata;
        `RTA_ADDR_WDOG:    wdog <= reg_wdata;
        `RTA_ADDR_AL_MON:  alarm_month_ctrl <= reg_wdata;
        `RTA_ADDR_AL_DAY:  alarm_day_repeat <= reg_wdata; // see RQ6
        `RTA_ADDR_AL_HOUR: alarm_hour_repeat <= reg_wdata;
        `RTA_ADDR_AL_MIN:  alarm_minute_repeat <= reg_wdata;
        `RTA_ADDR_AL_SEC:  alarm_second_repeat <= reg_wdata;
        default:           ;
      endcase
    end

    // fail flag: only a written zero clears it, and a live stop wins
    if (wr_flags && !reg_wdata[`RTA_BIT_OF])
      osc_fail_flag <= 1'b0; // see RQ14
    if (!run_stable || osc_halt_bit)
      osc_fail_flag <= 1'b1; // see RQ14 see RQ15 see RQ16

    // timeout flag: cleared by a flag read or a watchdog rewrite
    if (rd_flags ||
        (reg_wr && !ptr_set && ptr == `RTA_ADDR_WDOG))
      wdog_timeout_flag <= 1'b0; // see RQ23
    if (wdog_timeout && wdog_programmed)
      wdog_timeout_flag <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt pin

wire any_src_on;
wire pull_low;

assign any_src_on = alarm_irq_enable || osc_fail_irq_enable ||
                    wdog_programmed;
// a flag read leaves the fail term alone; only its enable or flag does
assign pull_low = any_src_on ?
  ((alarm_match_flag && alarm_irq_enable) ||            // see RQ5 RQ9
   (osc_fail_flag && osc_fail_irq_enable) ||            // see RQ19
   (wdog_timeout_flag && wdog_programmed)) :
  !fcomp[`RTA_BIT_OUT_LVL];                             // see RQ20

// open drain: the driven level is always low, release is high-z
assign int_n_o  = 1'b0; // see RQ21
assign int_n_oe = pull_low; // see RQ21

endmodule // rta_alarm_logic

//--- rta_alarm_logic_properties.sv
// port-level checks of the alarm and interrupt logic
`timescale 1ns/100ps
module rta_alarm_props
(
  input wire       sys_clk,
  input wire       sys_rst,
  input wire       osc_tick_pin,
  input wire       osc_run_pin,
  input wire       ptr_set,
  input wire [3:0] ptr_value,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [3:0] reg_ptr,
  input wire       wdog_timeout,
  input wire       wdog_programmed,
  input wire       int_n_i,
  input wire       int_n_o,
  input wire       int_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
////////////////////////////////////////
  chk_pin_open_drain:
    assert property (int_n_o == 1'b0)
    else $error("interrupt pin driven high");
  chk_reset_state:
    assert property ($fell(sys_rst) |->
      reg_ptr == 4'h0 && reg_rdata == 8'h00 && !int_n_oe)
    else $error("state after reset wrong");
  chk_ptr_step:
    assert property ((reg_rd || reg_wr) && !ptr_set |=>
      reg_ptr == $past(reg_ptr) + 4'h1)
    else $error("pointer did not advance by one");
  chk_flags_after_sec:
    assert property (reg_wr && !ptr_set && reg_ptr == 4'hE |=>
      reg_ptr == 4'hF)
    else $error("pointer not on flags after second alarm write");
  chk_wdog_source:
    assert property (reg_wr && !ptr_set && reg_ptr == 4'h9 |=>
      wdog_programmed == ($past(reg_wdata) != 8'h00 &&
      {$past(reg_wdata[7]), $past(reg_wdata[1:0])} <= 3'h4))
    else $error("watchdog enable does not follow register");
  chk_osc_stop_flag:
    assert property ((!osc_run_pin) [*8] ##0
      (reg_rd && !reg_wr && !ptr_set && reg_ptr == 4'hF) |=> reg_rdata[2])
    else $error("stopped oscillator not flagged");
  chk_flags_hold_alarm:
    assert property (reg_ptr == 4'hF && $past(reg_ptr) == 4'hF &&
      osc_run_pin && !$past(wdog_timeout) |-> !$rose(int_n_oe))
    else $error("interrupt raised while pointer on flags");
  chk_reread_zero:
    assert property (reg_rd && !reg_wr && !ptr_set && reg_ptr == 4'hF ##1
      ptr_set && ptr_value == 4'hF ##1 reg_rd && !reg_wr && !ptr_set
      |=> reg_rdata[6] == 1'b0)
    else $error("alarm flag survived a flag read");
endmodule // rta_alarm_props

bind rta_alarm_logic rta_alarm_props i_props
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .osc_tick_pin(osc_tick_pin),
  .osc_run_pin(osc_run_pin), .ptr_set(ptr_set), .ptr_value(ptr_value),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .wdog_timeout(wdog_timeout),
  .wdog_programmed(wdog_programmed), .int_n_i(int_n_i),
  .int_n_o(int_n_o), .int_n_oe(int_n_oe)
);

//--- rta_osc_model.sv
// oscillator model: 1 Hz chain level and running indication
`timescale 1ns/100ps
module rta_osc_model
(
  output reg osc_tick_pin,
  output reg osc_run_pin
);
  initial
  begin
    osc_tick_pin = 1'b0;
    osc_run_pin  = 1'b1;
  end
  // edges land on falling clock edges, away from the sampling edge
  task step;
  begin
    osc_tick_pin = 1'b1;
    #240;
    osc_tick_pin = 1'b0;
    #240;
  end
  endtask
  // a stopped oscillator holds its chain still and drops run
  task run(input on);
  begin
    osc_run_pin = on;
  end
  endtask
endmodule // rta_osc_model

//--- testbench.sv
// self-checking bench of the alarm and interrupt logic
`timescale 1ns/100ps
`include "rta_regs.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         ptr_set = 1'b0;
  reg  [3:0]  ptr_value = 4'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         wdog_timeout = 1'b0;
  wire        osc_tick_pin;
  wire        osc_run_pin;
  wire [7:0]  reg_rdata;
  wire [3:0]  reg_ptr;
  wire        wdog_programmed;
  wire        int_n_o;
  wire        int_n_oe;
  wire        int_n = int_n_oe ? int_n_o : 1'b1;
  integer     fail_count = 0;
  integer     n_compared = 0;
  integer     i;
  reg  [7:0]  d;
  reg  [4:0]  c;
  reg  [34:0] codes = {`RTA_RPT_SECOND, `RTA_RPT_MINUTE, `RTA_RPT_HOUR,
                       `RTA_RPT_DAY, `RTA_RPT_MONTH, `RTA_RPT_YEAR, 5'h14};
  reg  [6:0]  hit = 7'h61;
  always #20 sys_clk = ~sys_clk;
  rta_osc_model i_rta_osc_model
  (
    .osc_tick_pin(osc_tick_pin), .osc_run_pin(osc_run_pin)
  );
  rta_alarm_logic i_rta_alarm_logic
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .osc_tick_pin(osc_tick_pin),
    .osc_run_pin(osc_run_pin), .ptr_set(ptr_set), .ptr_value(ptr_value),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .wdog_timeout(wdog_timeout),
    .wdog_programmed(wdog_programmed), .int_n_i(int_n),
    .int_n_o(int_n_o), .int_n_oe(int_n_oe)
  );
////////////////////////////////////////
  task check(input [95:0] name, input [7:0] exp, input [7:0] got);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // tasks are entered at a falling edge and return at one
  task wr(input [3:0] a, input [7:0] v);
  begin
    ptr_set = 1'b1;
    ptr_value = a;
    @(negedge sys_clk);
    ptr_set = 1'b0;
    reg_wr = 1'b1;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [3:0] a, output [7:0] v);
  begin
    ptr_set = 1'b1;
    ptr_value = a;
    @(negedge sys_clk);
    ptr_set = 1'b0;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  end
  endtask
  task wait_int(input exp);
    integer n;
  begin
    n = 0;
    while (int_n_oe !== exp && n < 30)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    check("int pin", exp, int_n_oe);
    if (int_n_oe !== exp)
      complete_run;
  end
  endtask
  task tick;
  begin
    i_rta_osc_model.step;
    repeat (12) @(negedge sys_clk);
  end
  endtask
  task cal(input [7:0] y, input [7:0] mo, input [7:0] da, input [3:0] a,
           input [7:0] exp);
  begin
    wr(`RTA_ADDR_SEC, `RTA_MAX_SEC);
    wr(`RTA_ADDR_MIN, `RTA_MAX_MIN);
    wr(`RTA_ADDR_HOUR, `RTA_MAX_HOUR);
    wr(`RTA_ADDR_DATE, da);
    wr(`RTA_ADDR_MONTH, mo);
    wr(`RTA_ADDR_YEAR, y);
    tick;
    rd(a, d);
    check("calendar", exp, d);
  end
  endtask
////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(`RTA_ADDR_FCOMP, d);
    check("freq comp", `RTA_RST_FCOMP, d);
    rd(`RTA_ADDR_FLAGS, d);
    check("osc flag", 8'h01, d[`RTA_BIT_OF]);
    wr(`RTA_ADDR_FCOMP, 8'h00);
    wait_int(1'b1);
    wr(`RTA_ADDR_FCOMP, `RTA_RST_FCOMP);
    wait_int(1'b0);
    $display("test reset and out level done");
    for (i = 0; i < 7; i = i + 1)
    begin
      c = codes[34 - 5 * i -: 5];
      wr(`RTA_ADDR_AL_MON, 8'h85);
      wr(`RTA_ADDR_AL_DAY, {c[3], c[4], 6'h05});
      wr(`RTA_ADDR_AL_HOUR, {c[2], 7'h05});
      wr(`RTA_ADDR_AL_MIN, {c[1], 7'h05});
      wr(`RTA_ADDR_AL_SEC, {c[0], 3'h0, i[3:0] + 4'h1});
      check("pointer", 8'h0F, reg_ptr);
      tick;
      check("int pin", 8'h00, int_n_oe);
      rd(4'h0, d);
      repeat (6) @(negedge sys_clk);
      check("int pin", hit[6 - i], int_n_oe);
      rd(`RTA_ADDR_FLAGS, d);
      check("alarm flag", hit[6 - i], d[`RTA_BIT_AF]);
      check("int pin", 8'h00, int_n_oe);
      rd(`RTA_ADDR_FLAGS, d);
      check("alarm flag", 8'h00, d[`RTA_BIT_AF]);
    end
    wr(`RTA_ADDR_AL_DAY, 8'h00);
    wr(`RTA_ADDR_AL_HOUR, 8'h00);
    wr(`RTA_ADDR_AL_MIN, 8'h00);
    wr(`RTA_ADDR_AL_SEC, 8'h00);
    $display("test alarm repeat done");
    cal(8'h99, 8'h12, 8'h31, `RTA_ADDR_MONTH, 8'h41);
    cal(8'h99, 8'hD2, 8'h31, `RTA_ADDR_MONTH, 8'h01);
    cal(8'h04, 8'h02, 8'h28, `RTA_ADDR_DATE, 8'h29);
    cal(8'h00, 8'h02, 8'h28, `RTA_ADDR_DATE, 8'h29);
    cal(8'h01, 8'h02, 8'h28, `RTA_ADDR_DATE, 8'h01);
    $display("test calendar done");
    wr(`RTA_ADDR_AL_MON, 8'h40);
    wait_int(1'b1);
    rd(`RTA_ADDR_FLAGS, d);
    check("int pin", 8'h01, int_n_oe);
    wr(`RTA_ADDR_FLAGS, 8'h00);
    wait_int(1'b0);
    i_rta_osc_model.run(1'b0);
    wait_int(1'b1);
    repeat (4) @(negedge sys_clk);
    rd(`RTA_ADDR_FLAGS, d);
    check("osc flag", 8'h01, d[`RTA_BIT_OF]);
    i_rta_osc_model.run(1'b1);
    repeat (10) @(negedge sys_clk);
    check("int pin", 8'h01, int_n_oe);
    repeat (4) tick;
    wr(`RTA_ADDR_FLAGS, 8'h00);
    wait_int(1'b0);
    wr(`RTA_ADDR_SEC, 8'h80);
    wait_int(1'b1);
    wr(`RTA_ADDR_SEC, 8'h00);
    repeat (4) tick;
    wr(`RTA_ADDR_FLAGS, 8'h00);
    wait_int(1'b0);
    $display("test oscillator fail done");
    wr(`RTA_ADDR_AL_MON, 8'h00);
    wr(`RTA_ADDR_WDOG, 8'h0E);
    check("wdog on", 8'h01, wdog_programmed);
    wdog_timeout = 1'b1;
    @(negedge sys_clk);
    wdog_timeout = 1'b0;
    wait_int(1'b1);
    rd(`RTA_ADDR_FLAGS, d);
    check("wdog flag", 8'h01, d[`RTA_BIT_WDF]);
    rd(`RTA_ADDR_FLAGS, d);
    check("wdog flag", 8'h00, d[`RTA_BIT_WDF]);
    wr(`RTA_ADDR_WDOG, 8'h81);
    check("wdog on", 8'h00, wdog_programmed);
    wr(`RTA_ADDR_WDOG, 8'h00);
    check("wdog on", 8'h00, wdog_programmed);
    $display("test watchdog source done");
    complete_run;
  end
endmodule // testbench
